/* verilog/adcsc_defines.svh */
// register map, field positions and timing counts of the converter control
`ifndef ADCSC_DEFINES_SVH
`define ADCSC_DEFINES_SVH
// register byte offsets
`define ADCSC_OFF_CTRL      8'h00
`define ADCSC_OFF_SELECT    8'h04
`define ADCSC_OFF_RES_LOW   8'h08
`define ADCSC_OFF_RES_HIGH  8'h0C
`define ADCSC_OFF_STATUS    8'h10
// control register fields
`define ADCSC_CTRL_ENABLE   7
`define ADCSC_CTRL_START    6
`define ADCSC_CTRL_FLAG     4
`define ADCSC_CTRL_IE       3
// select register fields
`define ADCSC_SEL_LEFT      5
`define ADCSC_SEL_CHAN_MSB  4
// status register fields
`define ADCSC_STAT_BUSY     0
`define ADCSC_STAT_FIRST    1
`define ADCSC_STAT_SLEEP    2
// conversion lengths in converter clock periods
`define ADCSC_FIRST_CYCLES  5'h19
`define ADCSC_NORMAL_CYCLES 5'h0D
// differential channel code range
`define ADCSC_DIFF_FIRST    5'h08
`define ADCSC_DIFF_LAST     5'h1D
// result codes and saturation limits
`define ADCSC_SE_MAX        10'h3FF
`define ADCSC_DIFF_MAX      10'h1FF
`define ADCSC_DIFF_MIN      10'h200
`define ADCSC_RAW_POS_LIM   11'h1FF
`define ADCSC_RAW_NEG_LIM   11'h600
// bus responses
`define ADCSC_RESP_OKAY     2'h0
`define ADCSC_RESP_SLVERR   2'h2
`endif

/* verilog/adcsc_pkg.sv */
// types shared by the converter control block
package adcsc_pkg;
  // sleep state reported by the sleep controller
  typedef enum logic [2:0] {
    SLP_IDLE, SLP_NOISE, SLP_POWER_DOWN, SLP_POWER_SAVE,
    SLP_STANDBY, SLP_EXT_STANDBY
  } adcsc_sleep_type;
  // conversion sequencer states
  typedef enum logic {ST_IDLE, ST_CONV} adcsc_state_type;
endpackage

/* verilog/adcsc_fmt.sv */
// result saturation and left/right adjustment into two bytes
`timescale 1ns/100ps
`default_nettype none
`include "adcsc_defines.svh"
module adcsc_fmt (
  // raw core code and mode
  input  wire logic [10:0] raw_code,
  input  wire logic        diff,
  // stored result and presentation
  input  wire logic [9:0]  result,
  input  wire logic        left_adjust,
  // outputs
  output logic      [9:0]  sat_code,
  output logic      [7:0]  result_low_byte,
  output logic      [7:0]  result_high_byte
);
  // clamp raw core code to the 10-bit result range
  always_comb begin
    sat_code = raw_code[9:0]; // R14
    if (diff) begin
      if ($signed(raw_code) > $signed(`ADCSC_RAW_POS_LIM))
        sat_code = `ADCSC_DIFF_MAX; // R13
      else if ($signed(raw_code) < $signed(`ADCSC_RAW_NEG_LIM))
        sat_code = `ADCSC_DIFF_MIN; // R13
    end else if (raw_code[10]) begin
      sat_code = `ADCSC_SE_MAX; // R12
    end
  end
  // place ten result bits across the byte pair
  always_comb begin
    if (left_adjust) begin
      result_high_byte = result[9:2]; // R15 R19
      result_low_byte  = {result[1:0], 6'h00};
    end else begin
      result_high_byte = {6'h00, result[9:8]};
      result_low_byte  = result[7:0]; // R15 R19
    end
  end
endmodule // adcsc_fmt
`default_nettype wire

/* verilog/adcsc_top.sv */
// converter control: sleep-triggered start, sequencing, result registers
//
// Notes on behaviour
// [R1] halted idle/quiet sleep starts a conversion
// [R2] software prepares converter before such sleep
// [R3] completion interrupt wakes the halted CPU
// [R4] early wake still finishes conversion and flags
// [R5] only a new sleep entry retriggers
// [R6] other sleep states keep enable unchanged
// [R7] software should disable before deep sleep
// [R8] software re-enables for valid differential result
// [R9] software keeps shared pins quiet while converting
// [R10] same input on both terminals is allowed
// [R11] result held in byte pair once flagged
// [R12] single-ended code unsigned, 0x000 to 0x3FF
// [R13] differential code two's complement, saturating
// [R14] top result bit is the sign
// [R15] left-adjust bit selects result alignment
// [R16] alignment change takes effect at once
// [R17] software writes start bit per conversion
// [R18] first conversion 25 cycles, else 13
// [R19] byte placement for each alignment
// [R20] flag and result appear together; irq=flag&ie
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "adcsc_defines.svh"
module adcsc_top #(
  parameter int unsigned PRESCALE = 2,
  parameter int unsigned ADDR_W   = 8
) (
  // clock and reset
  input  wire logic                   CLK,
  input  wire logic                   ARST_N,
  // register bus write channels
  input  wire logic [ADDR_W-1:0]      S_AXI_AWADDR,
  input  wire logic                   S_AXI_AWVALID,
  output logic                        S_AXI_AWREADY,
  input  wire logic [31:0]            S_AXI_WDATA,
  input  wire logic [3:0]             S_AXI_WSTRB,
  input  wire logic                   S_AXI_WVALID,
  output logic                        S_AXI_WREADY,
  output logic      [1:0]             S_AXI_BRESP,
  output logic                        S_AXI_BVALID,
  input  wire logic                   S_AXI_BREADY,
  // register bus read channels
  input  wire logic [ADDR_W-1:0]      S_AXI_ARADDR,
  input  wire logic                   S_AXI_ARVALID,
  output logic                        S_AXI_ARREADY,
  output logic      [31:0]            S_AXI_RDATA,
  output logic      [1:0]             S_AXI_RRESP,
  output logic                        S_AXI_RVALID,
  input  wire logic                   S_AXI_RREADY,
  // cpu and sleep controller
  input  wire adcsc_pkg::adcsc_sleep_type SLEEP_MODE,
  input  wire logic                   CPU_HALTED,
  output logic                        IRQ,
  output logic                        CONVERTER_ON,
  // converter core
  output logic      [4:0]             CORE_CHANNEL,
  output logic                        CORE_DIFF,
  output logic                        CORE_INIT,
  output logic                        CORE_SAMPLE,
  output logic                        CORE_BUSY,
  input  wire logic [10:0]            CORE_CODE
);
  import adcsc_pkg::*;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  localparam logic [7:0] DIV_LAST = 8'(PRESCALE - 1);

  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic              aw_full_reg, aw_full_next;
  logic [31:0]       wdata_reg, wdata_next;
  logic              wstrb0_reg, wstrb0_next;
  logic              w_full_reg, w_full_next;
  logic              bvalid_reg, bvalid_next;
  logic [1:0]        bresp_reg, bresp_next;
  logic              rvalid_reg, rvalid_next;
  logic [31:0]       rdata_reg, rdata_next;
  logic [1:0]        rresp_reg, rresp_next;
  logic              do_write, wr_hit, wr_ctrl, wr_sel, ar_hs, rd_hit;
  logic [31:0]       rd_mux;
  logic [7:0]        div_reg, div_next;
  logic              tick;
  adcsc_state_type   state_reg, state_next;
  logic [4:0]        cnt_reg, cnt_next;
  logic              enable_reg, enable_next, ie_reg, ie_next;
  logic              flag_reg, flag_next, pend_reg, pend_next;
  logic              first_reg, first_next, left_reg, left_next;
  logic [4:0]        chan_reg, chan_next, lock_reg, lock_next;
  logic              ldiff_reg, ldiff_next, sample_reg, sample_next;
  logic              linit_reg, linit_next;
  logic              halted_reg, slpconv_reg, slpconv_next;
  logic [9:0]        result_reg, result_next, sat_code;
  logic [7:0]        res_low, res_high;
  logic              sleep_trig, conv_start, conv_done, abort, sel_diff;

  // write channel handshakes and commit
  assign S_AXI_AWREADY = !aw_full_reg && !bvalid_reg;
  assign S_AXI_WREADY  = !w_full_reg && !bvalid_reg;
  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_hit   = aw_addr_reg == ADDR_W'(`ADCSC_OFF_CTRL) ||
                    aw_addr_reg == ADDR_W'(`ADCSC_OFF_SELECT);
  assign wr_ctrl  = do_write && wstrb0_reg &&
                    aw_addr_reg == ADDR_W'(`ADCSC_OFF_CTRL);
  assign wr_sel   = do_write && wstrb0_reg &&
                    aw_addr_reg == ADDR_W'(`ADCSC_OFF_SELECT);

  // write channel next state
  always_comb begin
    aw_addr_next = aw_addr_reg;
    aw_full_next = aw_full_reg;
    wdata_next   = wdata_reg;
    wstrb0_next  = wstrb0_reg;
    w_full_next  = w_full_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_full_next = 1'b1;
      aw_addr_next = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_full_next = 1'b1;
      wdata_next  = S_AXI_WDATA;
      wstrb0_next = S_AXI_WSTRB[0];
    end
    if (do_write) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_hit ? `ADCSC_RESP_OKAY : `ADCSC_RESP_SLVERR;
    end else if (bvalid_reg && S_AXI_BREADY) begin
      bvalid_next = 1'b0;
    end
  end

  // read decode of live state and presented result
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (S_AXI_ARADDR)
      ADDR_W'(`ADCSC_OFF_CTRL): begin
        rd_mux[`ADCSC_CTRL_ENABLE] = enable_reg;
        rd_mux[`ADCSC_CTRL_START]  = pend_reg || state_reg == ST_CONV;
        rd_mux[`ADCSC_CTRL_FLAG]   = flag_reg;
        rd_mux[`ADCSC_CTRL_IE]     = ie_reg;
      end
      ADDR_W'(`ADCSC_OFF_SELECT): begin
        rd_mux[`ADCSC_SEL_LEFT]            = left_reg;
        rd_mux[`ADCSC_SEL_CHAN_MSB:0]      = chan_reg;
      end
      ADDR_W'(`ADCSC_OFF_RES_LOW):  rd_mux[7:0] = res_low;
      ADDR_W'(`ADCSC_OFF_RES_HIGH): rd_mux[7:0] = res_high;
      ADDR_W'(`ADCSC_OFF_STATUS): begin
        rd_mux[`ADCSC_STAT_BUSY]  = state_reg == ST_CONV;
        rd_mux[`ADCSC_STAT_FIRST] = first_reg;
        rd_mux[`ADCSC_STAT_SLEEP] = slpconv_reg;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // read channel next state
  assign ar_hs = S_AXI_ARVALID && !rvalid_reg;
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (ar_hs) begin
      rvalid_next = 1'b1;
      rdata_next  = rd_mux;
      rresp_next  = rd_hit ? `ADCSC_RESP_OKAY : `ADCSC_RESP_SLVERR;
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_next = 1'b0;
    end
  end

  // bus registers
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_addr_reg <= '0;
      aw_full_reg <= 1'b0;
      wdata_reg   <= 32'h0000_0000;
      wstrb0_reg  <= 1'b0;
      w_full_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `ADCSC_RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `ADCSC_RESP_OKAY;
    end else begin
      aw_addr_reg <= aw_addr_next;
      aw_full_reg <= aw_full_next;
      wdata_reg   <= wdata_next;
      wstrb0_reg  <= wstrb0_next;
      w_full_reg  <= w_full_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // result saturation and byte placement
  adcsc_fmt u_fmt (
    .raw_code         (CORE_CODE),
    .diff             (ldiff_reg),
    .result           (result_reg),
    .left_adjust      (left_reg),
    .sat_code         (sat_code),
    .result_low_byte  (res_low),
    .result_high_byte (res_high)
  );

  // sequencing terms
  assign tick     = div_reg == DIV_LAST;
  assign sel_diff = chan_reg >= `ADCSC_DIFF_FIRST &&
                    chan_reg <= `ADCSC_DIFF_LAST;
  assign abort    = wr_ctrl && !wdata_reg[`ADCSC_CTRL_ENABLE];
  assign sleep_trig = CPU_HALTED && !halted_reg && enable_reg && ie_reg &&
                      (SLEEP_MODE == SLP_IDLE || SLEEP_MODE == SLP_NOISE) &&
                      state_reg == ST_IDLE && !pend_reg; // R1 R5
  assign conv_start = state_reg == ST_IDLE && pend_reg && tick && !abort;
  assign conv_done  = state_reg == ST_CONV && tick && cnt_reg == 5'h01 &&
                      !abort; // R4

  // control bits and conversion sequencer next state
  always_comb begin
    div_next     = tick ? 8'h00 : div_reg + 8'h01;
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    enable_next  = enable_reg; // R6
    ie_next      = ie_reg;
    pend_next    = pend_reg;
    first_next   = first_reg;
    left_next    = left_reg;
    chan_next    = chan_reg;
    lock_next    = lock_reg;
    ldiff_next   = ldiff_reg;
    linit_next   = linit_reg;
    result_next  = result_reg;
    slpconv_next = slpconv_reg;
    sample_next  = conv_start;
    if (wr_sel) begin
      left_next = wdata_reg[`ADCSC_SEL_LEFT]; // R16
      chan_next = wdata_reg[`ADCSC_SEL_CHAN_MSB:0]; // R10
    end
    if (wr_ctrl) begin
      enable_next = wdata_reg[`ADCSC_CTRL_ENABLE];
      ie_next     = wdata_reg[`ADCSC_CTRL_IE];
      if (wdata_reg[`ADCSC_CTRL_START] && wdata_reg[`ADCSC_CTRL_ENABLE] &&
          state_reg == ST_IDLE)
        pend_next = 1'b1;
    end
    if (sleep_trig) begin
      pend_next    = 1'b1; // R1
      slpconv_next = 1'b1;
    end
    // channel follows the select register except while converting
    if (state_reg == ST_IDLE) begin
      lock_next  = chan_reg;
      ldiff_next = sel_diff;
    end
    if (conv_start) begin
      state_next = ST_CONV;
      pend_next  = 1'b0;
      linit_next = first_reg;
      first_next = 1'b0;
      cnt_next   = first_reg ? `ADCSC_FIRST_CYCLES
                             : `ADCSC_NORMAL_CYCLES; // R18
    end else if (state_reg == ST_CONV && tick) begin
      cnt_next = cnt_reg - 5'h01;
    end
    if (conv_done) begin
      state_next   = ST_IDLE;
      result_next  = sat_code; // R11 R12 R13 R20
      slpconv_next = 1'b0;
    end
    if (abort) begin
      state_next   = ST_IDLE;
      pend_next    = 1'b0;
      first_next   = 1'b1;
      slpconv_next = 1'b0;
    end
    // a completion in the clearing cycle keeps the flag set
    flag_next = conv_done ||
                (flag_reg && !(wr_ctrl && wdata_reg[`ADCSC_CTRL_FLAG]));
  end

  // control and sequencer registers
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_reg     <= 8'h00;
      state_reg   <= ST_IDLE;
      cnt_reg     <= 5'h00;
      enable_reg  <= 1'b0;
      ie_reg      <= 1'b0;
      flag_reg    <= 1'b0;
      pend_reg    <= 1'b0;
      first_reg   <= 1'b1;
      left_reg    <= 1'b0;
      chan_reg    <= 5'h00;
      lock_reg    <= 5'h00;
      ldiff_reg   <= 1'b0;
      linit_reg   <= 1'b0;
      sample_reg  <= 1'b0;
      result_reg  <= 10'h000;
      slpconv_reg <= 1'b0;
      halted_reg  <= 1'b0;
    end else begin
      div_reg     <= div_next;
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      enable_reg  <= enable_next;
      ie_reg      <= ie_next;
      flag_reg    <= flag_next; // R20
      pend_reg    <= pend_next;
      first_reg   <= first_next;
      left_reg    <= left_next;
      chan_reg    <= chan_next;
      lock_reg    <= lock_next;
      ldiff_reg   <= ldiff_next;
      linit_reg   <= linit_next;
      sample_reg  <= sample_next;
      result_reg  <= result_next;
      slpconv_reg <= slpconv_next;
      halted_reg  <= CPU_HALTED; // R5
    end
  end

  // outputs
  assign IRQ           = flag_reg && ie_reg; // R3 R20
  assign CONVERTER_ON  = enable_reg;
  assign CORE_CHANNEL  = lock_reg;
  assign CORE_DIFF     = ldiff_reg;
  assign CORE_INIT     = linit_reg;
  assign CORE_SAMPLE   = sample_reg;
  assign CORE_BUSY     = state_reg == ST_CONV;
  assign S_AXI_BVALID  = bvalid_reg;
  assign S_AXI_BRESP   = bresp_reg;
  assign S_AXI_ARREADY = !rvalid_reg;
  assign S_AXI_RVALID  = rvalid_reg;
  assign S_AXI_RDATA   = rdata_reg;
  assign S_AXI_RRESP   = rresp_reg;

  // clock count of each conversion, for the length check
  logic [15:0] len_reg;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N)
      len_reg <= 16'h0000;
    else
      len_reg <= conv_start ? 16'h0000 : len_reg + 16'h0001;
  end

  sleep_start_a: assert property ( // R1
    sleep_trig |=> pend_reg ##[1:256] CORE_SAMPLE)
    else $error("sleep entry did not start a conversion");
  wake_irq_a: assert property ( // R3
    conv_done && ie_reg && !wr_ctrl |=> IRQ)
    else $error("completion did not raise the interrupt");
  wake_finish_a: assert property ( // R4
    state_reg == ST_CONV && !abort && !conv_done |=> state_reg == ST_CONV)
    else $error("conversion stopped without disable");
  one_shot_a: assert property ( // R5
    !wr_ctrl && !(CPU_HALTED && !halted_reg) |=> !$rose(pend_reg))
    else $error("retrigger without a new sleep entry");
  enable_keep_a: assert property ( // R6
    !wr_ctrl |=> enable_reg == $past(enable_reg))
    else $error("enable changed without a write");
  same_input_a: assert property ( // R10
    CORE_SAMPLE |-> CORE_CHANNEL == $past(chan_reg))
    else $error("channel not taken from select register");
  result_hold_a: assert property ( // R11
    !conv_done |=> $stable(result_reg))
    else $error("result changed without a completion");
  se_range_a: assert property ( // R12
    conv_done && !ldiff_reg && CORE_CODE[10] |=> result_reg == `ADCSC_SE_MAX)
    else $error("single-ended code not clamped");
  diff_sat_a: assert property ( // R13
    conv_done && ldiff_reg &&
    $signed(CORE_CODE) < $signed(`ADCSC_RAW_NEG_LIM)
    |=> result_reg == `ADCSC_DIFF_MIN)
    else $error("differential code not clamped low");
  sign_bit_a: assert property ( // R14
    conv_done && ldiff_reg && CORE_CODE[10] |=> result_reg[9])
    else $error("negative result without sign bit");
  align_a: assert property ( // R15 R16 R19
    $rose(left_reg) |-> res_high == result_reg[9:2] &&
    res_low[5:0] == 6'h00)
    else $error("left alignment wrong");
  conv_len_a: assert property ( // R18
    conv_done |-> len_reg == 16'((linit_reg ? `ADCSC_FIRST_CYCLES
                                            : `ADCSC_NORMAL_CYCLES) *
                                 PRESCALE - 1))
    else $error("conversion length wrong");
  flag_result_a: assert property ( // R20
    conv_done |=> flag_reg && result_reg == $past(sat_code))
    else $error("flag and result not together");

  sleep_conv_c: cover property (sleep_trig ##[1:400] conv_done);
  first_conv_c: cover property (conv_done && linit_reg);
  diff_conv_c:  cover property (conv_done && ldiff_reg && CORE_CODE[10]);
  flag_race_c:  cover property (conv_done && wr_ctrl);
endmodule // adcsc_top
`default_nettype wire

/* dv/adcsc_cpu_model.sv */
// cpu sleep controller and converter core model for the bench
`timescale 1ns/100ps
`default_nettype none
module adcsc_cpu_model (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  // commands from the bench
  input  wire logic                       sleep_req,
  input  wire adcsc_pkg::adcsc_sleep_type sleep_sel,
  input  wire logic                       other_wake,
  input  wire logic [10:0]                code_val,
  // block side
  input  wire logic                       irq,
  input  wire logic                       core_busy,
  output var  adcsc_pkg::adcsc_sleep_type sleep_mode,
  output logic                            cpu_halted,
  output logic      [10:0]                core_code
);
  import adcsc_pkg::*;
  logic [10:0] junk_reg;
  // halt on a sleep entry, wake on an interrupt or a foreign wake
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sleep_mode <= SLP_IDLE;
      cpu_halted <= 1'b0;
      junk_reg   <= 11'h000;
    end else begin
      junk_reg <= ~junk_reg;
      if (sleep_req) begin
        sleep_mode <= sleep_sel;
        cpu_halted <= 1'b1;
      end else if (cpu_halted && (irq || other_wake)) begin
        cpu_halted <= 1'b0;
      end
    end
  end
  // core code is only meaningful while converting
  assign core_code = core_busy ? code_val : junk_reg;
endmodule // adcsc_cpu_model
`default_nettype wire

/* dv/adcsc_top_test.sv */
// self-checking bench of the sleep-triggered converter control
`timescale 1ns/100ps
`default_nettype none
`include "adcsc_defines.svh"
module adcsc_top_test;
  import adcsc_pkg::*;
  localparam int PRE = 1;
  logic            clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
  logic            awready, wready, bvalid, arready, rvalid, irq, conv_on;
  logic            sleep_req, other_wake, halted, core_busy, core_diff;
  logic [7:0]      awaddr, araddr;
  logic [31:0]     wdata, rdata;
  logic [1:0]      bresp, rresp;
  logic [10:0]     code_val, core_code;
  logic [4:0]      core_chan;
  adcsc_sleep_type sleep_sel, sleep_mode;
  int              bad_count, compares, cyc, run, last_run;

  adcsc_top #(.PRESCALE(PRE)) DUT (
    .CLK(clk), .ARST_N(arst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .SLEEP_MODE(sleep_mode), .CPU_HALTED(halted), .IRQ(irq),
    .CONVERTER_ON(conv_on), .CORE_CHANNEL(core_chan), .CORE_DIFF(core_diff),
    .CORE_INIT(), .CORE_SAMPLE(), .CORE_BUSY(core_busy),
    .CORE_CODE(core_code));

  adcsc_cpu_model cpu (
    .clk(clk), .arst_n(arst_n), .sleep_req(sleep_req),
    .sleep_sel(sleep_sel), .other_wake(other_wake), .code_val(code_val),
    .irq(irq), .core_busy(core_busy), .sleep_mode(sleep_mode),
    .cpu_halted(halted), .core_code(core_code));

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // busy run length and hang limit
  always @(posedge clk) begin
    cyc++;
    if (core_busy) run <= run + 1;
    else if (run != 0) begin
      last_run <= run;
      run      <= 0;
    end
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // bus write; handshakes judged at the falling edge before the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r  = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk("write response", r, er);
  endtask

  // bus read compared against the expected word and response
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                     input logic [1:0] er);
    logic ta, tb;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk);
      ta = arvalid && arready;
      tb = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk($sformatf("read data at %h", a), d, exp);
    chk("read response", r, er);
  endtask

  // one software-started conversion and its length in clock cycles
  task automatic conv(input logic [7:0] ctrl, input logic [10:0] code,
                      input int len);
    int n;
    code_val <= code;
    wr(`ADCSC_OFF_CTRL, {24'h0, ctrl}, `ADCSC_RESP_OKAY);
    n = 0;
    while (irq !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    chk("busy length", last_run, len);
    chk("irq", irq, 1'b1);
  endtask

  // both alignments of a stored result
  task automatic res(input logic [4:0] ch, input logic [9:0] r);
    wr(`ADCSC_OFF_SELECT, {27'h0, ch}, `ADCSC_RESP_OKAY);
    rdc(`ADCSC_OFF_RES_LOW, {24'h0, r[7:0]}, `ADCSC_RESP_OKAY);
    rdc(`ADCSC_OFF_RES_HIGH, {30'h0, r[9:8]}, `ADCSC_RESP_OKAY);
    wr(`ADCSC_OFF_SELECT, {26'h0, 1'b1, ch}, `ADCSC_RESP_OKAY);
    rdc(`ADCSC_OFF_RES_LOW, {24'h0, r[1:0], 6'h00}, `ADCSC_RESP_OKAY);
    rdc(`ADCSC_OFF_RES_HIGH, {24'h0, r[9:2]}, `ADCSC_RESP_OKAY);
  endtask

  // reset values, refused accesses and the first long conversion
  task automatic t_regs();
    rdc(`ADCSC_OFF_CTRL, 32'h0, `ADCSC_RESP_OKAY);
    rdc(`ADCSC_OFF_SELECT, 32'h0, `ADCSC_RESP_OKAY);
    rdc(`ADCSC_OFF_STATUS, 32'h2, `ADCSC_RESP_OKAY);
    rdc(8'h14, 32'h0, `ADCSC_RESP_SLVERR);
    wr(`ADCSC_OFF_RES_LOW, 32'hFF, `ADCSC_RESP_SLVERR);
    wr(8'h20, 32'hFF, `ADCSC_RESP_SLVERR);
    conv(8'hC8, 11'h155, 25 * PRE);
    res(5'h00, 10'h155);
  endtask

  // codes, clamping and sign across single and differential channels
  task automatic t_format();
    logic [4:0]  ch [6] = '{5'h07, 5'h1E, 5'h0D, 5'h10, 5'h1D, 5'h08};
    logic [10:0] cd [6] = '{11'h2A5, 11'h450, 11'h670, 11'h300, 11'h500,
                            11'h000};
    logic [9:0]  ex [6] = '{10'h2A5, 10'h3FF, 10'h270, 10'h1FF, 10'h200,
                            10'h000};
    for (int i = 0; i < 6; i++) begin
      wr(`ADCSC_OFF_SELECT, {27'h0, ch[i]}, `ADCSC_RESP_OKAY);
      @(negedge clk);
      chk("channel", core_chan, ch[i]);
      chk("diff", core_diff, ch[i] >= `ADCSC_DIFF_FIRST &&
                             ch[i] <= `ADCSC_DIFF_LAST);
      conv(8'hD8, cd[i], 13 * PRE);
      res(ch[i], ex[i]);
    end
  endtask

  // sleep entry with or without an early foreign wake
  task automatic sleep_run(input adcsc_sleep_type m, input logic early,
                           input logic starts, input logic [7:0] ctrl);
    int n;
    wr(`ADCSC_OFF_CTRL, {24'h0, ctrl}, `ADCSC_RESP_OKAY);
    sleep_sel <= m;
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    if (early) begin
      repeat (3) @(posedge clk);
      other_wake <= 1'b1;
      @(posedge clk);
      other_wake <= 1'b0;
    end
    n = 0;
    while (irq !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    chk("sleep irq", irq, starts);
    chk("converter on", conv_on, ctrl[7]);
    if (starts) chk("sleep busy length", last_run, 13 * PRE);
    repeat (40) @(posedge clk);
    chk("busy after wake", core_busy, 1'b0);
  endtask

  task automatic t_sleep();
    sleep_run(SLP_NOISE, 1'b0, 1'b1, 8'h98);
    sleep_run(SLP_IDLE, 1'b1, 1'b1, 8'h98);
    for (int m = 2; m < 6; m++)
      sleep_run(adcsc_sleep_type'(m), 1'b1, 1'b0, 8'h98);
    // off and on after waking forces a long conversion
    wr(`ADCSC_OFF_CTRL, 32'h0, `ADCSC_RESP_OKAY);
    conv(8'hD8, 11'h1AA, 25 * PRE);
    sleep_run(SLP_POWER_DOWN, 1'b1, 1'b0, 8'h18);
  endtask

  // reset, scenarios, verdict
  initial begin
    arst_n     = 1'b0;
    awvalid    = 1'b0;
    wvalid     = 1'b0;
    bready     = 1'b0;
    arvalid    = 1'b0;
    rready     = 1'b0;
    awaddr     = 8'h00;
    araddr     = 8'h00;
    wdata      = 32'h0;
    sleep_req  = 1'b0;
    other_wake = 1'b0;
    sleep_sel  = SLP_IDLE;
    code_val   = 11'h000;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_format();
    t_sleep();
    stop_test();
  end
endmodule // adcsc_top_test
`default_nettype wire
